// File: rtl/light_sensor_port.sv
// Sensor end of the two-wire register port.
// What this block does
// - Works at any bus rate 10 kHz to 400 kHz.
// - First variant answers address 0x29 (0x52/0x53).
// - Second variant answers address 0x10 (0x20/0x21).
// - Address byte LSB selects write zero, read one.
// - Eight-bit command codes 0x00 to 0x17 select registers.
// - Codes 0x02, 0x03, 0x08-0x0F, 0x16 are reserved.
// - Host writes both configuration registers together.
// - Shutdown keeps last result readable.
// - Line low 25 to 35 ms is timeout.
// - Configuration 0x00 bit 0 powers down core, resets one.
// - Configuration 0x01 bit 7 powers down channels.
// - Visible result low at 0x10, high 0x11, read-only.
`include "light_sensor_regs.svh"
`default_nettype none
module light_sensor_port
  import light_sensor_pkg::*;
#(
  parameter bit          ALT_ADDRESS    = 1'b0,
  parameter int          TIMEOUT_CYCLES = `LS_TIMEOUT_CYC,
  parameter logic [15:0] ID_CODE        = 16'h5A01  // Arbitrary value.
) (
  // Clock, reset and enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Serial link
  i2c_link_if.device       link,
  // Measurement side
  input  wire logic [15:0] als_result,
  input  wire logic [15:0] ir_result,
  input  wire logic        result_valid,
  input  wire logic [7:0]  int_events,
  // Configuration and status
  output logic             core_power_down,
  output logic             channel_power_down,
  output logic [7:0]       conf0,
  output logic [7:0]       conf1,
  output logic [15:0]      thresh_high,
  output logic [15:0]      thresh_low,
  output logic             bus_timeout,
  output logic             reserved_access
);

  // --------------------------------------------------------------------------
  // Constants, helpers and state
  // --------------------------------------------------------------------------
  localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [6:0] MY_ADDR = ALT_ADDRESS ? `LS_ADDR_B : `LS_ADDR_A;
  function automatic logic is_reserved(input logic [7:0] code);
    is_reserved = (code == 8'h02) || (code == 8'h03) ||
                  (code >= 8'h08 && code <= 8'h0F) ||
                  (code == `LS_CMD_RSV_16) || (code > `LS_CMD_LAST);
  endfunction
  dev_state_t      state;
  dev_phase_t      phase;
  logic [3:0]      bitcnt;
  logic [7:0]      shreg, tx, ptr, int_hold, rd_byte;
  logic [7:0]      cfg [0:5];
  logic [15:0]     als_hold, ir_hold;
  logic [TO_W-1:0] to_cnt;
  logic            reading, nack, sda_oe, sda_o, to_hit, scl_q, sda_q;
  logic            scl_rise, scl_fall, start_cond, stop_cond, timeout_fire;
  logic            abort, byte_done, addr_hit, load_rd, wr_en;

  // --------------------------------------------------------------------------
  // Line events and bus timeout
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      scl_q <= link.scl;
      sda_q <= link.sda;
    end
  end

  assign scl_rise     = link.scl && !scl_q;
  assign scl_fall     = !link.scl && scl_q;
  assign start_cond   = link.scl && scl_q && sda_q && !link.sda;
  assign stop_cond    = link.scl && scl_q && !sda_q && link.sda;
  assign timeout_fire = !to_hit && (to_cnt == TO_W'(TIMEOUT_CYCLES));
  assign abort        = timeout_fire || start_cond || stop_cond;
  assign byte_done    = !abort && state == ST_RECV && scl_fall &&
                        bitcnt == 4'h8;
  assign addr_hit     = shreg[7:1] == MY_ADDR;
  assign load_rd      = !abort && scl_fall &&
                        ((state == ST_ACK && phase == PH_ADDR && reading) ||
                         (state == ST_MACK && !nack));
  assign wr_en        = byte_done && phase == PH_DATA;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      to_cnt      <= '0;
      to_hit      <= 1'b0;
      bus_timeout <= 1'b0;
    end else if (ce) begin
      bus_timeout <= timeout_fire;
      if (timeout_fire) begin
        to_hit <= 1'b1;
      end else if (link.scl && link.sda) begin
        to_cnt <= '0;
        to_hit <= 1'b0;
      end else if (!to_hit) begin
        to_cnt <= to_cnt + TO_W'(1);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Protocol engine and registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state   <= ST_IDLE;
      phase   <= PH_ADDR;
      bitcnt  <= 4'h0;
      shreg   <= 8'h00;
      tx      <= 8'h00;
      reading <= 1'b0;
      nack    <= 1'b0;
      sda_oe  <= 1'b0;
      sda_o   <= 1'b0;
    end else if (ce) begin
      if (timeout_fire || stop_cond) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (start_cond) begin
        state  <= ST_RECV;
        phase  <= PH_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_RECV: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], link.sda};
              bitcnt <= bitcnt + 4'h1;
            end else if (byte_done) begin
              if (phase == PH_ADDR && !addr_hit) begin
                state <= ST_IDLE;
              end else begin
                state  <= ST_ACK;
                sda_oe <= 1'b1;
              end
              if (phase == PH_ADDR) begin
                reading <= shreg[0] == `LS_DIR_READ;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bitcnt <= 4'h0;
              if (phase == PH_ADDR && reading) begin
                state  <= ST_SEND;
                tx     <= rd_byte;
                sda_oe <= !rd_byte[7];
                phase  <= PH_DATA;
              end else begin
                state  <= ST_RECV;
                sda_oe <= 1'b0;
                phase  <= (phase == PH_ADDR) ? PH_CMD : PH_DATA;
              end
            end
          end
          ST_SEND: begin
            if (scl_rise) begin
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                state  <= ST_MACK;
                sda_oe <= 1'b0;
              end else begin
                tx     <= {tx[6:0], 1'b0};
                sda_oe <= !tx[6];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              nack <= link.sda;
            end else if (scl_fall) begin
              if (nack) begin
                state <= ST_IDLE;
              end else begin
                state  <= ST_SEND;
                bitcnt <= 4'h0;
                tx     <= rd_byte;
                sda_oe <= !rd_byte[7];
              end
            end
          end
          default: begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr             <= 8'h00;
      reserved_access <= 1'b0;
    end else if (ce) begin
      reserved_access <= byte_done && phase == PH_CMD && is_reserved(shreg);
      if (byte_done && phase == PH_CMD) begin
        ptr <= shreg;
      end else if (wr_en || load_rd) begin
        ptr <= ptr + 8'h01;
      end
    end
  end

  for (genvar i = 0; i < 6; i++) begin : g_cfg
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        cfg[i] <= (i == 0) ? `LS_CONF0_RST : `LS_REG_RST;
      end else if (ce && wr_en && ptr == 8'((i < 2) ? i : i + 2)) begin
        cfg[i] <= shreg;
      end
    end
  end

  assign conf0              = cfg[0];
  assign conf1              = cfg[1];
  assign thresh_high        = {cfg[3], cfg[2]};
  assign thresh_low         = {cfg[5], cfg[4]};
  assign core_power_down    = cfg[0][`LS_CORE_PD_BIT];
  assign channel_power_down = cfg[1][`LS_CHAN_PD_BIT];

  // --------------------------------------------------------------------------
  // Results, held while shut down, and read selection
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      als_hold <= `LS_DATA_RST;
      ir_hold  <= `LS_DATA_RST;
      int_hold <= `LS_REG_RST;
    end else if (ce) begin
      int_hold <= int_events;
      if (result_valid && !core_power_down && !channel_power_down) begin
        als_hold <= als_result;
        ir_hold  <= ir_result;
      end
    end
  end

  always_comb begin
    case (ptr)
      `LS_CMD_CONF0: rd_byte = cfg[0];
      `LS_CMD_CONF1: rd_byte = cfg[1];
      `LS_CMD_WH_L:  rd_byte = cfg[2];
      `LS_CMD_WH_H:  rd_byte = cfg[3];
      `LS_CMD_WL_L:  rd_byte = cfg[4];
      `LS_CMD_WL_H:  rd_byte = cfg[5];
      `LS_CMD_ALS_L: rd_byte = als_hold[7:0];
      `LS_CMD_ALS_H: rd_byte = als_hold[15:8];
      `LS_CMD_IR_L:  rd_byte = ir_hold[7:0];
      `LS_CMD_IR_H:  rd_byte = ir_hold[15:8];
      `LS_CMD_ID_L:  rd_byte = ID_CODE[7:0];
      `LS_CMD_ID_H:  rd_byte = ID_CODE[15:8];
      `LS_CMD_INT:   rd_byte = int_hold;
      default:       rd_byte = 8'h00;
    endcase
  end

  assign link.sda_dev_o  = sda_o;
  assign link.sda_dev_oe = sda_oe;
endmodule
`default_nettype wire

// File: rtl/light_sensor_regs.svh
// Constants of the light sensor serial port: addresses, codes, resets, timing.
`ifndef LIGHT_SENSOR_REGS_SVH
`define LIGHT_SENSOR_REGS_SVH

// ----------------------------------------------------------------------------
// Target addresses (7 bit) and direction bit
// ----------------------------------------------------------------------------
`define LS_ADDR_A        7'h29
`define LS_ADDR_B        7'h10
`define LS_DIR_READ      1'b1
`define LS_DIR_WRITE     1'b0

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define LS_CMD_CONF0     8'h00
`define LS_CMD_CONF1     8'h01
`define LS_CMD_WH_L      8'h04
`define LS_CMD_WH_H      8'h05
`define LS_CMD_WL_L      8'h06
`define LS_CMD_WL_H      8'h07
`define LS_CMD_ALS_L     8'h10
`define LS_CMD_ALS_H     8'h11
`define LS_CMD_IR_L      8'h12
`define LS_CMD_IR_H      8'h13
`define LS_CMD_ID_L      8'h14
`define LS_CMD_ID_H      8'h15
`define LS_CMD_RSV_16    8'h16
`define LS_CMD_INT       8'h17
`define LS_CMD_LAST      8'h17

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define LS_CORE_PD_BIT   0
`define LS_CHAN_PD_BIT   7
`define LS_CONF0_RST     8'h01
`define LS_REG_RST       8'h00
`define LS_DATA_RST      16'h0000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define LS_CLK_KHZ       200000
`define LS_CLK_HZ        200000000
`define LS_TIMEOUT_MS    25
`define LS_TIMEOUT_CYC   (`LS_TIMEOUT_MS * `LS_CLK_KHZ)
`define LS_SCL_MIN_HZ    10000
`define LS_SCL_MAX_HZ    400000
`define LS_SCL_DEF_HZ    100000

`endif

// File: rtl/light_sensor_pkg.sv
// Types shared by both ends of the light sensor serial port.
`default_nettype none
package light_sensor_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_ACK  = 3'b011,
    ST_SEND = 3'b010,
    ST_MACK = 3'b110
  } dev_state_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_CMD  = 2'b01,
    PH_DATA = 2'b11
  } dev_phase_t;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_START = 2'b01,
    H_BIT   = 2'b11,
    H_STOP  = 2'b10
  } host_state_t;

endpackage
`default_nettype wire

// File: rtl/i2c_link_if.sv
// Open-drain two-wire link joining the host end and the sensor end.
`default_nettype none
interface i2c_link_if;
  logic scl_host_o;
  logic scl_host_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;

  // A line is low when any enabled driver pulls it low, else pulled up.
  assign scl = !(scl_host_oe && !scl_host_o);
  assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));

  modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host (input scl, input sda, output scl_host_o, output scl_host_oe,
                output sda_host_o, output sda_host_oe);
endinterface
`default_nettype wire

// File: rtl/light_sensor_host.sv
// Host end: issues word writes and word reads to the sensor port.
`include "light_sensor_regs.svh"
`default_nettype none
module light_sensor_host
  import light_sensor_pkg::*;
#(
  parameter int SCL_HZ = `LS_SCL_DEF_HZ
) (
  // Clock, reset and enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Serial link
  i2c_link_if.host         link,
  // Request
  input  wire logic        req_valid,
  input  wire logic        req_read,
  input  wire logic [6:0]  req_addr,
  input  wire logic [7:0]  req_code,
  input  wire logic [15:0] req_wdata,
  output logic             req_ready,
  // Answer
  output logic             done,
  output logic             got_nack,
  output logic [15:0]      rdata
);

  // --------------------------------------------------------------------------
  // Bus rate, kept inside the supported range
  // --------------------------------------------------------------------------
  localparam int SCL_USE = (SCL_HZ < `LS_SCL_MIN_HZ) ? `LS_SCL_MIN_HZ :
                           (SCL_HZ > `LS_SCL_MAX_HZ) ? `LS_SCL_MAX_HZ :
                           SCL_HZ;
  localparam int QUARTER = (`LS_CLK_HZ + 4 * SCL_USE - 1) / (4 * SCL_USE);
  localparam int Q_W     = $clog2(QUARTER + 1);

  host_state_t    state;
  logic [Q_W-1:0] qcnt;
  logic [1:0]     qph;
  logic           tick;
  logic [3:0]     bitn;
  logic [2:0]     seq;
  logic [7:0]     tx;
  logic [7:0]     rx;
  logic           ack_bad;
  logic           op_read;
  logic [6:0]     addr;
  logic [7:0]     code;
  logic [15:0]    wdata;
  logic           scl_oe;
  logic           sda_oe;
  logic           rx_byte;

  // Byte sent at each step of a transfer.
  function automatic logic [7:0] tx_of(input logic [2:0] s);
    case (s)
      3'h0:    tx_of = {addr, `LS_DIR_WRITE};
      3'h1:    tx_of = code;
      3'h2:    tx_of = op_read ? {addr, `LS_DIR_READ} : wdata[7:0];
      3'h3:    tx_of = wdata[15:8];
      default: tx_of = 8'h00;
    endcase
  endfunction

  assign tick    = qcnt == Q_W'(QUARTER - 1);
  assign rx_byte = op_read && seq >= 3'h3;

  // --------------------------------------------------------------------------
  // Quarter-bit timer
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      qcnt <= '0;
    end else if (ce) begin
      qcnt <= (state == H_IDLE || tick) ? '0 : qcnt + Q_W'(1);
    end
  end

  // --------------------------------------------------------------------------
  // Transfer sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state     <= H_IDLE;
      qph       <= 2'h0;
      bitn      <= 4'h0;
      seq       <= 3'h0;
      tx        <= 8'h00;
      rx        <= 8'h00;
      ack_bad   <= 1'b0;
      op_read   <= 1'b0;
      addr      <= 7'h00;
      code      <= 8'h00;
      wdata     <= 16'h0000;
      scl_oe    <= 1'b0;
      sda_oe    <= 1'b0;
      req_ready <= 1'b1;
      done      <= 1'b0;
      got_nack  <= 1'b0;
      rdata     <= 16'h0000;
    end else if (ce) begin
      done <= 1'b0;
      if (state == H_IDLE) begin
        if (req_valid) begin
          state     <= H_START;
          req_ready <= 1'b0;
          op_read   <= req_read;
          addr      <= req_addr;
          code      <= req_code;
          wdata     <= req_wdata;
          seq       <= 3'h0;
          qph       <= 2'h0;
          got_nack  <= 1'b0;
        end
      end else if (tick) begin
        qph <= qph + 2'h1;
        case (state)
          H_START: begin
            case (qph)
              2'h0:    sda_oe <= 1'b0;
              2'h1:    scl_oe <= 1'b0;
              2'h2:    sda_oe <= 1'b1;
              default: begin
                scl_oe <= 1'b1;
                state  <= H_BIT;
                bitn   <= 4'h0;
                tx     <= tx_of(seq);
              end
            endcase
          end
          H_BIT: begin
            case (qph)
              2'h0: begin
                if (bitn != 4'h8) begin
                  sda_oe <= !rx_byte && !tx[7];
                end else begin
                  sda_oe <= rx_byte && seq == 3'h3;
                end
              end
              2'h1: scl_oe <= 1'b0;
              2'h2: begin
                if (bitn == 4'h8) begin
                  ack_bad <= link.sda;
                end else if (rx_byte) begin
                  rx <= {rx[6:0], link.sda};
                end else begin
                  tx <= {tx[6:0], 1'b0};
                end
              end
              default: begin
                scl_oe <= 1'b1;
                bitn   <= bitn + 4'h1;
                if (bitn == 4'h8) begin
                  bitn <= 4'h0;
                  seq  <= seq + 3'h1;
                  tx   <= tx_of(seq + 3'h1);
                  if (!rx_byte && ack_bad) begin
                    got_nack <= 1'b1;
                    state    <= H_STOP;
                  end else if (rx_byte && seq == 3'h3) begin
                    rdata[7:0] <= rx;
                  end else if (rx_byte) begin
                    rdata[15:8] <= rx;
                    state       <= H_STOP;
                  end else if (!op_read && seq == 3'h3) begin
                    state <= H_STOP;
                  end else if (op_read && seq == 3'h1) begin
                    state <= H_START;
                  end
                end
              end
            endcase
          end
          H_STOP: begin
            case (qph)
              2'h0:    sda_oe <= 1'b1;
              2'h1:    scl_oe <= 1'b0;
              2'h2:    sda_oe <= 1'b0;
              default: begin
                state     <= H_IDLE;
                done      <= 1'b1;
                req_ready <= 1'b1;
              end
            endcase
          end
          default: state <= H_IDLE;
        endcase
      end
    end
  end

  assign link.scl_host_o  = 1'b0;
  assign link.scl_host_oe = scl_oe;
  assign link.sda_host_o  = 1'b0;
  assign link.sda_host_oe = sda_oe;

endmodule
`default_nettype wire

// File: dv/light_sensor_link_assertions.sv
// Concurrent checks on the two-wire link between both ends.
`default_nettype none
module light_sensor_link_assertions #(
  parameter int         QUARTER = 125,
  parameter logic [6:0] ADDR    = 7'h29
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link levels and device drive
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        scl_q;
  logic        sda_q;
  logic        idle;
  logic [4:0]  rises;
  logic [7:0]  shift;
  logic [15:0] per_cnt;
  wire         start = scl && scl_q && sda_q && !sda;
  wire         stop  = scl && scl_q && !sda_q && sda;
  wire         rise  = scl && !scl_q;

  // --------
  // Bus state
  // --------
  always_ff @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (rise) shift <= {shift[6:0], sda};
  end
  always_ff @(posedge clk) begin
    if (!rst_n || stop) idle <= 1'b1;
    else if (start) idle <= 1'b0;
  end
  always_ff @(posedge clk) begin
    if (!rst_n || start) rises <= 5'h00;
    else if (rise && rises != 5'h1F) rises <= rises + 5'h01;
  end
  // Cycles since the last clock rise, loaded at full scale by reset and held there once it saturates.
  always_ff @(posedge clk) begin
    if (!rst_n) per_cnt <= 16'hFFFF;
    else if (rise) per_cnt <= 16'h0000;
    else if (per_cnt != 16'hFFFF) per_cnt <= per_cnt + 16'h0001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_ACK_AFTER_FALL: assert property ($rose(sda_dev_oe) |-> !scl &&
    !$past(scl) && ($past(scl, 2) || $past(scl, 3)))
    else $error("drive not after a clock fall");
  AST_STEADY_HIGH: assert property (scl && $past(scl) |->
    $stable(sda_dev_oe)) else $error("drive changed while clock high");
  AST_NO_DEV_FRAME: assert property ($changed(sda) && scl &&
    $past(scl) |-> !sda_dev_oe && !$past(sda_dev_oe))
    else $error("device made a start or stop");
  AST_SCL_PERIOD: assert property (rise |->
    per_cnt >= 16'(4 * QUARTER - 1)) else $error("clock too fast");
  AST_BITS_FIRST: assert property ($rose(sda_dev_oe) |->
    rises >= 5'd8) else $error("drive before address byte");
  AST_ACK_STANDS: assert property ($rose(sda_dev_oe) |=>
    sda_dev_oe [*8]) else $error("drive too short");
  AST_QUIET_IDLE: assert property (idle |-> !sda_dev_oe)
    else $error("drive on idle bus");
  AST_ADDR_MATCH: assert property ($rose(sda_dev_oe) &&
    rises == 5'd8 |-> shift[7:1] == ADDR) else $error("wrong address acked");

  cover property ($rose(sda_dev_oe) && rises == 5'd8);
  cover property (start && !idle);
  cover property (stop);
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Top testbench: host end and sensor end joined over one link.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TO = 20000;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        host_ce = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_read = 1'b0;
  logic [6:0]  req_addr = 7'h00;
  logic [7:0]  req_code = 8'h00;
  logic [15:0] req_wdata = 16'h0000;
  logic        req_ready;
  logic        done;
  logic        got_nack;
  logic [15:0] rdata;
  logic [15:0] als_result = 16'h0000;
  logic [15:0] ir_result = 16'h0000;
  logic        result_valid = 1'b0;
  logic [7:0]  int_events = 8'h00;
  logic        core_power_down;
  logic        channel_power_down;
  logic [7:0]  conf0;
  logic [7:0]  conf1;
  logic        bus_timeout;
  logic        reserved_access;
  logic [15:0] rsv_cnt = 16'h0000;
  logic [15:0] to_cnt = 16'h0000;
  int          error_cnt = 0;
  int          total_checks = 0;

  i2c_link_if link ();

  light_sensor_host #(.SCL_HZ(400000)) light_sensor_host_i (.clk, .rst_n,
    .ce(host_ce), .link, .req_valid, .req_read, .req_addr, .req_code,
    .req_wdata, .req_ready, .done, .got_nack, .rdata);
  light_sensor_port #(.TIMEOUT_CYCLES(TO)) light_sensor_port_i (.clk,
    .rst_n, .ce(1'b1), .link, .als_result, .ir_result, .result_valid,
    .int_events, .core_power_down, .channel_power_down, .conf0, .conf1,
    .thresh_high(), .thresh_low(), .bus_timeout, .reserved_access);
  light_sensor_link_assertions light_sensor_link_assertions_i (.clk,
    .rst_n, .scl(link.scl), .sda(link.sda), .sda_dev_oe(link.sda_dev_oe));

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (reserved_access === 1'b1) rsv_cnt <= rsv_cnt + 16'h0001;
    if (bus_timeout === 1'b1) to_cnt <= to_cnt + 16'h0001;
  end

  // --------
  // Tasks
  // --------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // One word transfer; frz stalls the host with the clock held low.
  task automatic xfer(input logic rd, input logic [6:0] a,
    input logic [7:0] c, input logic [15:0] w, input bit frz);
    int n;
    req_valid <= 1'b1;
    req_read <= rd;
    req_addr <= a;
    req_code <= c;
    req_wdata <= w;
    @(posedge clk);
    req_valid <= 1'b0;
    if (frz) begin
      repeat (1000) @(posedge clk);
      for (n = 0; n < 600 && link.scl !== 1'b1; n++) @(posedge clk);
      for (n = 0; n < 600 && link.scl !== 1'b0; n++) @(posedge clk);
      host_ce <= 1'b0;
      repeat (TO + 100) @(posedge clk);
      host_ce <= 1'b1;
    end
    for (n = 0; n < 40000 && done !== 1'b1; n++) @(posedge clk);
    chk({15'h0000, done}, 16'h0001);
  endtask

  task automatic pulse(input logic [15:0] v);
    @(posedge clk);
    als_result <= v;
    ir_result <= ~v;
    result_valid <= 1'b1;
    @(posedge clk);
    result_valid <= 1'b0;
  endtask

  task automatic t_defaults();
    chk({14'h0000, channel_power_down, core_power_down}, 16'h0001);
    chk({conf1, conf0}, 16'h0001);
  endtask

  task automatic t_power_up();
    xfer(1'b0, 7'h29, 8'h00, 16'h0000, 1'b0);
    chk({15'h0000, got_nack}, 16'h0000);
    chk({conf1, conf0}, 16'h0000);
    chk({14'h0000, channel_power_down, core_power_down}, 16'h0000);
    pulse(16'h1234);
  endtask

  task automatic t_retain();
    xfer(1'b0, 7'h29, 8'h00, 16'h8001, 1'b0);
    chk({conf1, conf0}, 16'h8001);
    chk({14'h0000, channel_power_down, core_power_down}, 16'h0003);
    pulse(16'hBEEF);
    xfer(1'b1, 7'h29, 8'h10, 16'h0000, 1'b0);
    chk({15'h0000, got_nack}, 16'h0000);
    chk(rdata, 16'h1234);
  endtask

  task automatic t_reserved();
    int_events <= 8'hA5;
    xfer(1'b1, 7'h29, 8'h16, 16'h0000, 1'b0);
    chk(rdata, 16'hA500);
    chk(rsv_cnt, 16'h0001);
  endtask

  task automatic t_stuck();
    xfer(1'b0, 7'h10, 8'h00, 16'h0000, 1'b1);
    chk({15'h0000, got_nack}, 16'h0001);
    chk(to_cnt, 16'h0001);
  endtask

  task automatic test_done();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_defaults();
    t_power_up();
    t_retain();
    t_reserved();
    t_stuck();
    test_done();
  end

  initial begin
    repeat (200000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire
